// ==== logic/pcr_pkg.sv ====
// constants, types and decode helpers for the regulator configuration bank
package pcr_pkg;

  localparam logic [5:0] DEV_ADDR_HI = 6'h3A;
  localparam int         NUM_REGS    = 11;

  localparam logic [7:0] OFS_VOUT1 = 8'h00;
  localparam logic [7:0] OFS_TIM1  = 8'h03;
  localparam logic [7:0] OFS_CAP1  = 8'h06;
  localparam logic [7:0] OFS_RATE  = 8'h09;
  localparam logic [7:0] OFS_PWR   = 8'h0A;
  localparam logic [7:0] LAST_OFS  = OFS_PWR;

  localparam logic [7:0] RST_VOUT   = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h15;
  localparam logic [7:0] RST_CAP    = 8'h05;
  localparam logic [7:0] RST_RATE   = 8'h42;
  localparam logic [7:0] RST_PWR    = 8'h7F;

  localparam logic [7:0] MSK_VOUT   = 8'hFF;
  localparam logic [7:0] MSK_TIMING = 8'h77;
  localparam logic [7:0] MSK_CAP    = 8'h07;
  localparam logic [7:0] MSK_RATE   = 8'h7F;
  localparam logic [7:0] MSK_PWR    = 8'h4F;

  localparam int VOUT_EXT_BIT = 7;
  localparam int TIM_DLY_LSB  = 4;
  localparam int TIM_SST_LSB  = 0;
  localparam int RATE_PHS_LSB = 5;
  localparam int RATE_FRQ_LSB = 0;
  localparam int PWR_PSM_BIT  = 3;
  localparam int PWR_UV_BIT   = 6;

  localparam int         VOUT_BASE_MV  = 800;
  localparam int         VOUT_STEP_MV  = 50;
  localparam logic [6:0] VOUT_CODE_MAX = 7'h68;

  localparam int          CLK_MHZ      = 50;
  localparam int          LOAD_TIME_US = 200;
  localparam int unsigned LOAD_CYC     = LOAD_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK} pcr_state_t;
  typedef enum logic [1:0] {K_ADDR, K_SUB, K_DATA} pcr_kind_t;

  // writable bits of each register
  function automatic logic [7:0] pcr_reg_mask(input int idx);
    if (idx < 3) return MSK_VOUT;
    else if (idx < 6) return MSK_TIMING;
    else if (idx < 9) return MSK_CAP;
    else if (idx == 9) return MSK_RATE;
    else return MSK_PWR;
  endfunction : pcr_reg_mask

  // value loaded at power-on
  function automatic logic [7:0] pcr_reg_reset(input int idx);
    if (idx < 3) return RST_VOUT;
    else if (idx < 6) return RST_TIMING;
    else if (idx < 9) return RST_CAP;
    else if (idx == 9) return RST_RATE;
    else return RST_PWR;
  endfunction : pcr_reg_reset

  // target in millivolts, zero when external feedback rules
  function automatic logic [12:0] pcr_vout_mv(input logic ext, input logic [6:0] code);
    logic [6:0] c;
    c = (code > VOUT_CODE_MAX) ? VOUT_CODE_MAX : code;
    if (ext) return 13'h0000;
    return 13'(VOUT_BASE_MV + VOUT_STEP_MV * int'(c));
  endfunction : pcr_vout_mv

endpackage : pcr_pkg

// ==== logic/pcr_bit_io.sv ====
// serial line edge and start/stop detection
`timescale 1ns/1ps
`default_nettype none
module pcr_bit_io (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise_out,
  output logic      scl_fall_out,
  output logic      start_out,
  output logic      stop_out,
  output logic      sda_now_out
);
  logic scl_r;
  logic sda_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl_in;
      sda_r <= sda_in;
    end
  end

  assign scl_rise_out = scl_in & ~scl_r;
  assign scl_fall_out = ~scl_in & scl_r;
  assign start_out    = scl_in & scl_r & sda_r & ~sda_in;
  assign stop_out     = scl_in & scl_r & ~sda_r & sda_in;
  assign sda_now_out  = sda_in;
endmodule : pcr_bit_io
`default_nettype wire

// ==== logic/pcr_reg_file.sv ====
// configuration register storage, write masking and field fan-out
`timescale 1ns/1ps
`default_nettype none
module pcr_reg_file
  import pcr_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wr_data_in,
  output logic      [7:0]  rd_data_out,
  output logic      [20:0] voltage_code_out,
  output logic      [2:0]  ext_sel_out,
  output logic      [38:0] vout_mv_out,
  output logic      [8:0]  delay_out,
  output logic      [8:0]  softstart_out,
  output logic      [8:0]  cap_out,
  output logic      [1:0]  phase_out,
  output logic      [4:0]  rate_out,
  output logic      [2:0]  chsel_out,
  output logic             psm_out,
  output logic             uv_out
);
  logic [7:0] regs_r [NUM_REGS];
  wire        in_map = (addr_in <= LAST_OFS);

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        regs_r[i] <= pcr_reg_reset(i) & pcr_reg_mask(i); // [R6]
      end else if (wr_en_in && addr_in == 8'(i)) begin
        regs_r[i] <= wr_data_in & pcr_reg_mask(i); // [R12]
      end
    end
  end

  assign rd_data_out = in_map ? regs_r[addr_in[3:0]] : 8'h00; // [R12]

  for (genvar c = 0; c < 3; c++) begin : g_ch
    assign voltage_code_out[7*c +: 7] = regs_r[c][6:0]; // [R4]
    assign ext_sel_out[c]             = regs_r[c][VOUT_EXT_BIT];
    assign vout_mv_out[13*c +: 13]    = pcr_vout_mv(regs_r[c][VOUT_EXT_BIT], regs_r[c][6:0]); // [R5]
    assign delay_out[3*c +: 3]        = regs_r[3+c][TIM_DLY_LSB +: 3]; // [R7]
    assign softstart_out[3*c +: 3]    = regs_r[3+c][TIM_SST_LSB +: 3]; // [R7]
    assign cap_out[3*c +: 3]          = regs_r[6+c][2:0];
  end

  assign phase_out = regs_r[9][RATE_PHS_LSB +: 2]; // [R8]
  assign rate_out  = regs_r[9][RATE_FRQ_LSB +: 5]; // [R8]
  assign chsel_out = regs_r[10][2:0]; // [R11]
  assign psm_out   = regs_r[10][PWR_PSM_BIT]; // [R11]
  assign uv_out    = regs_r[10][PWR_UV_BIT];
endmodule : pcr_reg_file
`default_nettype wire

// ==== logic/pcr_top.sv ====
// two-wire slave and configuration bank of a three-channel buck regulator
// How it works
// R1 - answer one 7-bit address: 111010 plus the strap level
// R2 - address byte bit 0 is direction: 0 write, 1 read
// R3 - master sends address byte first after every start
// R4 - voltage code bits 6:0 give 0.8 V plus 0.05 V per step; the design holds codes above 68h at 6.0 V
// R5 - bit 7 set selects external feedback, code ignored
// R6 - voltage registers hold 00h after power-on load
// R7 - timing register: delay code bits 6:4, soft-start bits 2:0
// R8 - register 09h holds 2-bit phase and 5-bit frequency fields
// R9 - master sends 8-bit register address after address byte
// R10 - power-on load of defaults takes 200 us, bus ignored meanwhile
// R11 - power control bits 2:0 select channels, bit 3 pulse skipping
// R12 - unused bits read zero; offsets past last register acked, no effect
`timescale 1ns/1ps
`default_nettype none
module pcr_top
  import pcr_pkg::*;
#(
  parameter int unsigned LOAD_CYCLES = LOAD_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        address_strap_pin_in,
  output logic             loading_out,
  output logic      [6:0]  voltage_code_1_out,
  output logic      [6:0]  voltage_code_2_out,
  output logic      [6:0]  voltage_code_3_out,
  output logic             external_feedback_sel_1_out,
  output logic             external_feedback_sel_2_out,
  output logic             external_feedback_sel_3_out,
  output logic      [38:0] vout_target_mv_out,
  output logic      [8:0]  startup_delay_code_out,
  output logic      [8:0]  softstart_code_out,
  output logic      [8:0]  current_cap_code_out,
  output logic      [1:0]  phase_arrangement_out,
  output logic      [4:0]  switch_rate_code_out,
  output logic      [2:0]  channel_select_out,
  output logic             pulse_skip_enable_out,
  output logic             undervoltage_threshold_sel_out
);
  localparam int LCW = $clog2(LOAD_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // line events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_now;

  pcr_bit_io u_bit_io (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start_det),
    .stop_out     (stop_det),
    .sda_now_out  (sda_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  pcr_state_t     state_r;
  pcr_state_t     state_nxt;
  pcr_kind_t      kind_r;
  pcr_kind_t      kind_nxt;
  logic [3:0]     cnt_r;
  logic [3:0]     cnt_nxt;
  logic [7:0]     shreg_r;
  logic [7:0]     shreg_nxt;
  logic [7:0]     ptr_r;
  logic [7:0]     ptr_nxt;
  logic [7:0]     txsh_r;
  logic [7:0]     txsh_nxt;
  logic           read_r;
  logic           read_nxt;
  logic           mack_r;
  logic           mack_nxt;
  logic [LCW-1:0] load_cnt_r;
  logic           strap_r;
  logic           strap_ok_r;
  logic [7:0]     rd_data;

  // strap caught after reset release
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      strap_r    <= 1'b0;
      strap_ok_r <= 1'b0;
    end else if (!strap_ok_r) begin
      strap_r    <= address_strap_pin_in; // [R1]
      strap_ok_r <= 1'b1;
    end
  end

  // power-on load timer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      load_cnt_r <= '0;
    end else if (state_r == ST_LOAD) begin
      load_cnt_r <= load_cnt_r + LCW'(1); // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire load_done  = (load_cnt_r == LCW'(LOAD_CYCLES - 1));
  wire addr_match = (shreg_r[7:1] == {DEV_ADDR_HI, strap_r}); // [R1]
  wire byte_end   = (state_r == ST_RECV) && scl_fall && (cnt_r == 4'h8);
  wire wr_pulse   = byte_end && (kind_r == K_DATA);
  wire bus_live   = (state_r != ST_LOAD); // [R10]

  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    cnt_nxt   = cnt_r;
    shreg_nxt = shreg_r;
    ptr_nxt   = ptr_r;
    txsh_nxt  = txsh_r;
    read_nxt  = read_r;
    mack_nxt  = mack_r;
    case (state_r)
      ST_LOAD: begin
        if (load_done) begin
          state_nxt = ST_IDLE; // [R10]
        end
      end
      ST_IDLE: begin
        cnt_nxt = 4'h0;
      end
      ST_RECV: begin
        if (scl_rise && cnt_r != 4'h8) begin
          shreg_nxt = {shreg_r[6:0], sda_now};
          cnt_nxt   = cnt_r + 4'h1;
        end
        if (byte_end) begin
          case (kind_r)
            K_ADDR: begin
              read_nxt  = shreg_r[0]; // [R2]
              state_nxt = addr_match ? ST_ACK : ST_IDLE; // [R1] [R3]
            end
            K_SUB: begin
              ptr_nxt   = shreg_r; // [R9]
              state_nxt = ST_ACK;
            end
            default: begin
              ptr_nxt   = ptr_r + 8'h01;
              state_nxt = ST_ACK; // [R12]
            end
          endcase
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          cnt_nxt = 4'h0;
          if (read_r) begin
            txsh_nxt  = rd_data;
            state_nxt = ST_SEND; // [R2]
          end else begin
            state_nxt = ST_RECV;
            kind_nxt  = (kind_r == K_ADDR) ? K_SUB : K_DATA;
          end
        end
      end
      ST_SEND: begin
        if (scl_fall) begin
          txsh_nxt = {txsh_r[6:0], 1'b0};
          cnt_nxt  = cnt_r + 4'h1;
          if (cnt_r == 4'h7) begin
            state_nxt = ST_MACK;
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          mack_nxt = ~sda_now;
          if (!sda_now) begin
            ptr_nxt = ptr_r + 8'h01;
          end
        end
        if (scl_fall) begin
          cnt_nxt   = 4'h0;
          txsh_nxt  = rd_data;
          state_nxt = mack_r ? ST_SEND : ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (bus_live && stop_det) begin
      state_nxt = ST_IDLE;
    end
    if (bus_live && start_det) begin
      state_nxt = ST_RECV; // [R3]
      kind_nxt  = K_ADDR;
      cnt_nxt   = 4'h0;
      read_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_LOAD;
      kind_r  <= K_ADDR;
      cnt_r   <= 4'h0;
      shreg_r <= 8'h00;
      ptr_r   <= 8'h00;
      txsh_r  <= 8'h00;
      read_r  <= 1'b0;
      mack_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      cnt_r   <= cnt_nxt;
      shreg_r <= shreg_nxt;
      ptr_r   <= ptr_nxt;
      txsh_r  <= txsh_nxt;
      read_r  <= read_nxt;
      mack_r  <= mack_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain drive and registers
  assign sda_out     = 1'b0;
  assign sda_oe_out  = (state_r == ST_ACK) || (state_r == ST_SEND && !txsh_r[7]);
  assign loading_out = (state_r == ST_LOAD);

  logic [20:0] vcode;
  logic [2:0]  ext_sel;

  pcr_reg_file u_reg_file (
    .clk_sys_in       (clk_sys_in),
    .rst_in           (rst_in),
    .wr_en_in         (wr_pulse),
    .addr_in          (ptr_r),
    .wr_data_in       (shreg_r),
    .rd_data_out      (rd_data),
    .voltage_code_out (vcode),
    .ext_sel_out      (ext_sel),
    .vout_mv_out      (vout_target_mv_out),
    .delay_out        (startup_delay_code_out),
    .softstart_out    (softstart_code_out),
    .cap_out          (current_cap_code_out),
    .phase_out        (phase_arrangement_out),
    .rate_out         (switch_rate_code_out),
    .chsel_out        (channel_select_out),
    .psm_out          (pulse_skip_enable_out),
    .uv_out           (undervoltage_threshold_sel_out)
  );

  assign voltage_code_1_out          = vcode[6:0];
  assign voltage_code_2_out          = vcode[13:7];
  assign voltage_code_3_out          = vcode[20:14];
  assign external_feedback_sel_1_out = ext_sel[0];
  assign external_feedback_sel_2_out = ext_sel[1];
  assign external_feedback_sel_3_out = ext_sel[2];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  wire addr_end = byte_end && (kind_r == K_ADDR);

  addr_reject_a: assert property (addr_end && !addr_match |=> state_r == ST_IDLE && !sda_oe_out) // [R1]
    else $error("foreign address was not ignored");
  addr_ack_a: assert property (addr_end && addr_match |=> state_r == ST_ACK && sda_oe_out) // [R1]
    else $error("own address not acknowledged");
  dir_decode_a: assert property (addr_end && addr_match |=> read_r == $past(shreg_r[0])) // [R2]
    else $error("direction bit decoded wrongly");
  vout_step_a: assert property (!ext_sel[0] && vcode[6:0] <= VOUT_CODE_MAX |->
      vout_target_mv_out[12:0] == 13'(VOUT_BASE_MV + VOUT_STEP_MV * int'(vcode[6:0]))) // [R4]
    else $error("voltage target does not follow code");
  ext_override_a: assert property (ext_sel[1] |-> vout_target_mv_out[25:13] == 13'h0000) // [R5]
    else $error("external feedback did not override code");
  vout_reset_a: assert property (state_r == ST_LOAD |-> vcode == 21'h000000 && ext_sel == 3'h0) // [R6]
    else $error("voltage registers not zero after load");
  timing_write_a: assert property (wr_pulse && ptr_r == OFS_TIM1 |=>
      startup_delay_code_out[2:0] == $past(shreg_r[6:4]) &&
      softstart_code_out[2:0] == $past(shreg_r[2:0])) // [R7]
    else $error("timing fields not stored");
  rate_write_a: assert property (wr_pulse && ptr_r == OFS_RATE |=>
      phase_arrangement_out == $past(shreg_r[6:5]) &&
      switch_rate_code_out == $past(shreg_r[4:0])) // [R8]
    else $error("phase or frequency field not stored");
  load_quiet_a: assert property (state_r == ST_LOAD |-> !sda_oe_out && !wr_pulse) // [R10]
    else $error("bus active during power-on load");
  load_end_a: assert property (state_r == ST_LOAD && load_done |=> state_r == ST_IDLE) // [R10]
    else $error("power-on load did not end on time");
  pwr_write_a: assert property (wr_pulse && ptr_r == OFS_PWR |=>
      channel_select_out == $past(shreg_r[2:0]) &&
      pulse_skip_enable_out == $past(shreg_r[3])) // [R11]
    else $error("power control fields not stored");
  high_ofs_a: assert property (wr_pulse && ptr_r > LAST_OFS |=> state_r == ST_ACK &&
      $stable(vcode) && $stable(channel_select_out) && $stable(switch_rate_code_out)) // [R12]
    else $error("write past last register had an effect");

  write_seen_c: cover property (wr_pulse ##[1:40] state_r == ST_ACK);
  read_seen_c: cover property (state_r == ST_ACK && read_r ##1 state_r == ST_SEND);
  reject_seen_c: cover property (addr_end && !addr_match);
  burst_read_c: cover property (state_r == ST_MACK && mack_r && scl_fall);
endmodule : pcr_top
`default_nettype wire

// ==== verification/pcr_host_model.sv ====
// two-wire bus master model on the host side of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model (
  input  wire logic       clk_sys_in,
  input  wire logic [2:0] stretch_in,
  input  wire logic [6:0] dev_addr_in,
  input  wire logic       sda_line_in,
  output var  logic       scl_out,
  output var  logic       sda_oe_out
);
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : w

  ////////////////////////////////////////////////////////////////
  // one scl period, data set while low, line sampled mid high
  task automatic bit_io(input logic b, output logic r);
    scl_out = 1'b0;
    w(2);
    sda_oe_out = ~b;
    w(4);
    scl_out = 1'b1;
    w(3 + int'(stretch_in));
    r = sda_line_in;
    w(3);
  endtask : bit_io

  task automatic start_cond();
    scl_out = 1'b0;
    w(3);
    sda_oe_out = 1'b0;
    w(3);
    scl_out = 1'b1;
    w(6);
    sda_oe_out = 1'b1;
    w(6);
  endtask : start_cond

  task automatic stop_cond();
    scl_out = 1'b0;
    w(3);
    sda_oe_out = 1'b1;
    w(3);
    scl_out = 1'b1;
    w(6);
    sda_oe_out = 1'b0;
    w(6);
  endtask : stop_cond

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : get_byte

  ////////////////////////////////////////////////////////////////
  // register transfers
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic [2:0] acks);
    start_cond();
    put_byte({dev_addr_in, 1'b0}, acks[2]);
    put_byte(a, acks[1]);
    put_byte(d, acks[0]);
    stop_cond();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic [2:0] acks);
    start_cond();
    put_byte({dev_addr_in, 1'b0}, acks[2]);
    put_byte(a, acks[1]);
    start_cond();
    put_byte({dev_addr_in, 1'b1}, acks[0]);
    get_byte(1'b1, d);
    stop_cond();
  endtask : read_reg
endmodule : pcr_host_model
`default_nettype wire

// ==== verification/pcr_top_test.sv ====
// self-checking bench for the regulator configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcr_top_test;
  localparam int unsigned LOAD_N = 60;
  localparam logic [7:0] MSK [0:10] = '{8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h77, 8'h77,
                                        8'h07, 8'h07, 8'h07, 8'h7F, 8'h4F};
  localparam logic [7:0] DEF [0:10] = '{8'h00, 8'h00, 8'h00, 8'h15, 8'h15, 8'h15,
                                        8'h05, 8'h05, 8'h05, 8'h42, 8'h7F};
  logic        clk_sys_in;
  logic        rst_in;
  logic        strap;
  logic [2:0]  stretch;
  logic [6:0]  dev_a;
  logic [31:0] seed;
  logic        scl;
  logic        m_oe;
  logic        d_out;
  logic        d_oe;
  logic        loading;
  logic [6:0]  vc1, vc2, vc3;
  logic [2:0]  ext;
  logic [38:0] mv;
  logic [8:0]  dly, sst, cap;
  logic [1:0]  phase_arrangement;
  logic [4:0]  switch_rate_code;
  logic [2:0]  chs;
  logic        pulse_skip_enable, uv;
  logic [7:0]  exp_r [0:11];
  int          fails;
  int          num_checks;
  wire logic   sda = ~m_oe & (~d_oe | d_out);

  pcr_top #(.LOAD_CYCLES(LOAD_N)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(d_out), .sda_oe_out(d_oe), .address_strap_pin_in(strap), .loading_out(loading),
    .voltage_code_1_out(vc1), .voltage_code_2_out(vc2), .voltage_code_3_out(vc3),
    .external_feedback_sel_1_out(ext[0]), .external_feedback_sel_2_out(ext[1]),
    .external_feedback_sel_3_out(ext[2]), .vout_target_mv_out(mv),
    .startup_delay_code_out(dly), .softstart_code_out(sst), .current_cap_code_out(cap),
    .phase_arrangement_out(phase_arrangement), .switch_rate_code_out(switch_rate_code), .channel_select_out(chs),
    .pulse_skip_enable_out(pulse_skip_enable), .undervoltage_threshold_sel_out(uv));

  pcr_host_model m (.clk_sys_in(clk_sys_in), .stretch_in(stretch), .dev_addr_in(dev_a),
    .sda_line_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic w(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : w

  task automatic chk_val(input logic [38:0] got, input logic [38:0] want);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, want);
    end
  endtask : chk_val

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic load_defaults();
    for (int i = 0; i < 11; i++) exp_r[i] = DEF[i] & MSK[i];
    exp_r[11] = 8'h00;
  endtask : load_defaults

  task automatic wait_load();
    int n;
    n = 0;
    while (loading === 1'b1 && n < 200) begin
      w(1);
      n++;
    end
    chk_val(39'(n), 39'(LOAD_N));
  endtask : wait_load

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] ea);
    logic [2:0] acks;
    m.write_reg(a, d, acks);
    chk_val(39'(acks), 39'(ea));
    if (ea == 3'h7 && a < 8'h0B) exp_r[a] = d & MSK[a];
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    logic [2:0] acks;
    m.read_reg(a, d, acks);
    chk_val(39'(acks), 39'h7);
    chk_val(39'(d), 39'(exp_r[(a < 8'h0B) ? int'(a) : 11]));
  endtask : rd

  task automatic check_fields();
    logic [38:0] emv;
    logic [8:0]  edl, ess, ecp;
    int          k;
    for (int c = 0; c < 3; c++) begin
      k = (exp_r[c][6:0] > 7'h68) ? 104 : int'(exp_r[c][6:0]);
      emv[13*c +: 13] = exp_r[c][7] ? 13'h0000 : 13'(800 + 50 * k);
      edl[3*c +: 3] = exp_r[3+c][6:4];
      ess[3*c +: 3] = exp_r[3+c][2:0];
      ecp[3*c +: 3] = exp_r[6+c][2:0];
    end
    chk_val(39'({vc3, vc2, vc1}), 39'({exp_r[2][6:0], exp_r[1][6:0], exp_r[0][6:0]}));
    chk_val(39'(ext), 39'({exp_r[2][7], exp_r[1][7], exp_r[0][7]}));
    chk_val(mv, emv);
    chk_val(39'({dly, sst}), 39'({edl, ess}));
    chk_val(39'(cap), 39'(ecp));
    chk_val(39'({phase_arrangement, switch_rate_code}), 39'({exp_r[9][6:5], exp_r[9][4:0]}));
    chk_val(39'({uv, pulse_skip_enable, chs}), 39'({exp_r[10][6], exp_r[10][3], exp_r[10][2:0]}));
  endtask : check_fields

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    fails++;
    end_of_test();
  end

  initial begin
    rst_in = 1'b1;
    strap = 1'b0;
    stretch = 3'h0;
    seed = 32'hF5DE;
    fails = 0;
    num_checks = 0;
    dev_a = {6'h3A, 1'b0};
    load_defaults();
    w(3);
    rst_in = 1'b0;
    wait_load();
    $display("done load");
    for (int a = 0; a < 12; a++) rd(8'(a));
    check_fields();
    $display("done defaults");
    for (int a = 0; a < 13; a++) begin
      seed = lfsr_next(seed);
      stretch = seed[10:8];
      wr((a < 11) ? 8'(a) : ((a == 11) ? 8'h0B : 8'hFF), seed[7:0], 3'h7);
    end
    wr(8'h00, 8'h44, 3'h7);
    wr(8'h01, 8'hC5, 3'h7);
    wr(8'h02, 8'h7A, 3'h7);
    for (int a = 0; a < 12; a++) rd(8'(a));
    check_fields();
    $display("done writes");
    dev_a = {6'h3A, 1'b1};
    wr(8'h00, 8'h12, 3'h0);
    dev_a = {6'h3B, 1'b0};
    wr(8'h00, 8'h12, 3'h0);
    dev_a = {6'h3A, 1'b0};
    rd(8'h00);
    $display("done address");
    rst_in = 1'b1;
    strap = 1'b1;
    dev_a = {6'h3A, 1'b1};
    load_defaults();
    w(3);
    check_fields();
    rst_in = 1'b0;
    fork
      wait_load();
      wr(8'h00, 8'h33, 3'h0);
    join
    wr(8'h01, 8'h21, 3'h7);
    rd(8'h00);
    rd(8'h01);
    check_fields();
    $display("done reload");
    end_of_test();
  end
endmodule : pcr_top_test
`default_nettype wire
